// File: verilog/trg_pkg.sv
// Purpose: shared constants and types of the timed register write guard
// Assumes: registers are word indexed; byte address is four times index
// Notes:   index values equal the special-function or extended address
`default_nettype none

package trg_pkg;

  // register indices on the bus
  localparam logic [15:0] IDX_SINGLE_KEY   = 16'h00C7;
  localparam logic [15:0] IDX_WINDOW_KEY   = 16'h00C9;
  localparam logic [15:0] IDX_WDOG_CTRL    = 16'h00D8;
  localparam logic [15:0] IDX_XRAM_BASE    = 16'h00C6;
  localparam logic [15:0] IDX_ADDR_CONFIG  = 16'h009D;
  localparam logic [15:0] IDX_CLOCK_SELECT = 16'h008F;
  localparam logic [15:0] IDX_WAKE_MASK    = 16'h009F;

  // extended trim and configuration registers behind the window key
  localparam int          TRIM_N = 13;
  localparam logic [15:0] IDX_TRIM [TRIM_N] = '{
    16'hA000, 16'hA001, 16'hA002, 16'hA007, 16'hA010, 16'hA011, 16'hA016,
    16'hA025, 16'hA026, 16'hA013, 16'hA014, 16'hA0E1, 16'hA0EF
  };

  // unlock sequence bytes
  localparam logic [7:0] KEY_FIRST = 8'hAA;
  localparam logic [7:0] KEY_SECOND = 8'h55;
  localparam logic [7:0] KEY_CLOSE = 8'h00;

  // status bit position in both key registers
  localparam int STAT_BIT = 0;

  // reset values of guarded registers
  localparam logic [7:0] RST_WDOG_CTRL    = 8'h00;
  localparam logic [7:0] RST_XRAM_BASE    = 8'h00;
  localparam logic [7:0] RST_ADDR_CONFIG  = 8'h00;
  localparam logic [7:0] RST_CLOCK_SELECT = 8'h0C;
  localparam logic [7:0] RST_WAKE_MASK    = 8'hFF;
  localparam logic [7:0] RST_TRIM         = 8'h00;

  // write window length in system clock periods
  localparam int WINDOW_CYCLES = 256;

  typedef enum logic [1:0] {
    TRG_SK_LOCKED = 2'b00,
    TRG_SK_GOT_AA = 2'b01,
    TRG_SK_OPEN   = 2'b10
  } trg_sk_e;

  typedef struct packed {
    logic [7:0] wdog_ctrl;
    logic [7:0] xram_base;
    logic [7:0] addr_config;
    logic [7:0] clock_select;
    logic [7:0] wake_mask;
  } trg_prot_s;

endpackage

`default_nettype wire

// File: verilog/trg_window_timer.sv
// Purpose: write window countdown for the window key
// Assumes: reload and close are one-cycle pulses, never together
// Notes:   count freezes with the clock, so a stopped clock holds the window
`default_nettype none

module trg_window_timer #(
  parameter int CYCLES = trg_pkg::WINDOW_CYCLES
) (
  input  wire logic clk_sys_i,
  input  wire logic rst_i,
  input  wire logic reload_i,
  input  wire logic close_i,
  output logic      open_o
);

  localparam int CW = $clog2(CYCLES + 1);
  localparam logic [CW-1:0] FULL = CW'(CYCLES);
  localparam logic [CW-1:0] ONE  = CW'(1);

  logic [CW-1:0] cnt_q;

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      cnt_q  <= '0;
      open_o <= 1'b0;
    end else if (close_i) begin
      cnt_q  <= '0;
      open_o <= 1'b0;
    end else if (reload_i) begin
      cnt_q  <= FULL;
      open_o <= 1'b1;
    end else if (open_o) begin
      cnt_q  <= cnt_q - ONE;
      open_o <= (cnt_q != ONE);
    end
  end

  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);

  win_expire_a: assert property (open_o && cnt_q == ONE && !reload_i
    |=> !open_o) else $error("window did not close at expiry");
  win_reload_a: assert property (reload_i && !close_i
    |=> open_o && cnt_q == FULL) else $error("window reload wrong");
  win_count_a: assert property (open_o |-> cnt_q != '0)
    else $error("open window with zero count");

endmodule

`default_nettype wire

// File: verilog/trg_guard.sv
// Purpose: timed write guard for critical registers, Avalon-MM slave
// Assumes: word-addressed slave, index equals the register's printed offset
// Notes:   one wait state per access; read data is captured on the wait edge, other effects land on the accept edge, the single key flag one edge later
//
// The implementer's own choice: the Avalon-MM register port.
`default_nettype none

module trg_guard #(
  parameter int WINDOW_CYCLES = trg_pkg::WINDOW_CYCLES
) (
  input  wire logic                          clk_sys_i,
  input  wire logic                          rst_i,
  input  wire logic [15:0]                   avs_address_i,
  input  wire logic                          avs_read_i,
  input  wire logic                          avs_write_i,
  input  wire logic [31:0]                   avs_writedata_i,
  input  wire logic [3:0]                    avs_byteenable_i,
  output logic      [31:0]                   avs_readdata_o,
  output logic                               avs_waitrequest_o,
  output trg_pkg::trg_prot_s                 prot_regs_o,
  output logic      [trg_pkg::TRIM_N-1:0][7:0] trim_regs_o,
  output logic                               single_key_unlocked_flag_o,
  output logic                               window_open_flag_o
);

  // trim slot lookup: bit 4 valid, bits 3:0 slot
  function automatic logic [4:0] trim_slot(input logic [15:0] idx);
    logic [4:0] r;
    r = 5'h00;
    for (int i = 0; i < trg_pkg::TRIM_N; i++) begin
      if (idx == trg_pkg::IDX_TRIM[i]) begin
        r = {1'b1, 4'(i)};
      end
    end
    return r;
  endfunction

  function automatic logic single_guarded(input logic [15:0] idx);
    return idx == trg_pkg::IDX_WDOG_CTRL ||
           idx == trg_pkg::IDX_XRAM_BASE ||
           idx == trg_pkg::IDX_ADDR_CONFIG;
  endfunction

  function automatic logic window_guarded(input logic [15:0] idx);
    logic [4:0] s;
    s = trim_slot(idx);
    return idx == trg_pkg::IDX_CLOCK_SELECT ||
           idx == trg_pkg::IDX_WAKE_MASK ||
           s[4];
  endfunction

  trg_pkg::trg_sk_e sk_q;
  logic             wk_seq_q;
  logic             req;
  logic             commit;
  logic             wr_c;
  logic             rd_c;
  logic [7:0]       wdat;
  logic [4:0]       slot;
  logic             sk_hit;
  logic             wk_hit;
  logic             wk_reload;
  logic             wk_close;
  logic             sk_ok;
  logic             wk_ok;
  logic [7:0]       rd_mux;

  assign req    = avs_read_i | avs_write_i;
  assign commit = req & ~avs_waitrequest_o;
  assign wr_c   = commit & avs_write_i & avs_byteenable_i[0];
  assign rd_c   = commit & avs_read_i;
  assign wdat   = avs_writedata_i[7:0];
  assign slot   = trim_slot(avs_address_i);
  assign sk_hit = avs_address_i == trg_pkg::IDX_SINGLE_KEY;
  assign wk_hit = avs_address_i == trg_pkg::IDX_WINDOW_KEY;
  assign sk_ok  = sk_q == trg_pkg::TRG_SK_OPEN;
  assign wk_ok  = window_open_flag_o;

  assign wk_reload = wr_c & wk_hit & wk_seq_q
                     & (wdat == trg_pkg::KEY_SECOND);
  assign wk_close  = wr_c & wk_hit & (wdat == trg_pkg::KEY_CLOSE);

  // bus handshake: one wait cycle, then accept
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      avs_waitrequest_o <= 1'b1;
    end else begin
      avs_waitrequest_o <= !(req && avs_waitrequest_o);
    end
  end

  // single key ticket, no timeout
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      sk_q <= trg_pkg::TRG_SK_LOCKED;
    end else if (commit && sk_hit) begin
      if (sk_ok) begin
        sk_q <= trg_pkg::TRG_SK_LOCKED;
      end else if (wr_c) begin
        case (sk_q)
          trg_pkg::TRG_SK_GOT_AA: begin
            if (wdat == trg_pkg::KEY_SECOND) begin
              sk_q <= trg_pkg::TRG_SK_OPEN;
            end else if (wdat == trg_pkg::KEY_FIRST) begin
              sk_q <= trg_pkg::TRG_SK_GOT_AA;
            end else begin
              sk_q <= trg_pkg::TRG_SK_LOCKED;
            end
          end
          default: begin
            sk_q <= (wdat == trg_pkg::KEY_FIRST) ? trg_pkg::TRG_SK_GOT_AA
                                                 : trg_pkg::TRG_SK_LOCKED;
          end
        endcase
      end
    end else if (wr_c && single_guarded(avs_address_i) && sk_ok) begin
      sk_q <= trg_pkg::TRG_SK_LOCKED;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      single_key_unlocked_flag_o <= 1'b0;
    end else begin
      single_key_unlocked_flag_o <= sk_q == trg_pkg::TRG_SK_OPEN;
    end
  end

  // window key sequence tracking
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      wk_seq_q <= 1'b0;
    end else if (wr_c && wk_hit) begin
      wk_seq_q <= wdat == trg_pkg::KEY_FIRST;
    end
  end

  // count runs on the cpu clock only, so it freezes with it
  trg_window_timer #(
    .CYCLES (WINDOW_CYCLES)
  ) u_timer (
    .clk_sys_i (clk_sys_i),
    .rst_i     (rst_i),
    .reload_i  (wk_reload),
    .close_i   (wk_close),
    .open_o    (window_open_flag_o)
  );

  // guarded registers; writes without permission leave them unchanged
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      prot_regs_o.wdog_ctrl    <= trg_pkg::RST_WDOG_CTRL;
      prot_regs_o.xram_base    <= trg_pkg::RST_XRAM_BASE;
      prot_regs_o.addr_config  <= trg_pkg::RST_ADDR_CONFIG;
      prot_regs_o.clock_select <= trg_pkg::RST_CLOCK_SELECT;
      prot_regs_o.wake_mask    <= trg_pkg::RST_WAKE_MASK;
    end else if (wr_c && sk_ok) begin
      case (avs_address_i)
        trg_pkg::IDX_WDOG_CTRL:   prot_regs_o.wdog_ctrl   <= wdat;
        trg_pkg::IDX_XRAM_BASE:   prot_regs_o.xram_base   <= wdat;
        trg_pkg::IDX_ADDR_CONFIG: prot_regs_o.addr_config <= wdat;
        default: ;
      endcase
      if (wk_ok && avs_address_i == trg_pkg::IDX_CLOCK_SELECT) begin
        prot_regs_o.clock_select <= wdat;
      end
      if (wk_ok && avs_address_i == trg_pkg::IDX_WAKE_MASK) begin
        prot_regs_o.wake_mask <= wdat;
      end
    end else if (wr_c && wk_ok) begin
      case (avs_address_i)
        trg_pkg::IDX_CLOCK_SELECT: prot_regs_o.clock_select <= wdat;
        trg_pkg::IDX_WAKE_MASK:    prot_regs_o.wake_mask    <= wdat;
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      for (int i = 0; i < trg_pkg::TRIM_N; i++) begin
        trim_regs_o[i] <= trg_pkg::RST_TRIM;
      end
    end else if (wr_c && wk_ok && slot[4]) begin
      trim_regs_o[slot[3:0]] <= wdat;
    end
  end

  // read data, captured in the wait cycle
  always_comb begin
    rd_mux = 8'h00;
    case (avs_address_i)
      trg_pkg::IDX_SINGLE_KEY:   rd_mux[trg_pkg::STAT_BIT] = sk_ok;
      trg_pkg::IDX_WINDOW_KEY:   rd_mux[trg_pkg::STAT_BIT] = wk_ok;
      trg_pkg::IDX_WDOG_CTRL:    rd_mux = prot_regs_o.wdog_ctrl;
      trg_pkg::IDX_XRAM_BASE:    rd_mux = prot_regs_o.xram_base;
      trg_pkg::IDX_ADDR_CONFIG:  rd_mux = prot_regs_o.addr_config;
      trg_pkg::IDX_CLOCK_SELECT: rd_mux = prot_regs_o.clock_select;
      trg_pkg::IDX_WAKE_MASK:    rd_mux = prot_regs_o.wake_mask;
      default: begin
        if (slot[4]) begin
          rd_mux = trim_regs_o[slot[3:0]];
        end
      end
    endcase
  end

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      avs_readdata_o <= 32'h0000_0000;
    end else if (avs_read_i && avs_waitrequest_o) begin
      avs_readdata_o <= {24'h00_0000, rd_mux};
    end
  end

  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);

  tkt_grant_a: assert property (wr_c && sk_hit
      && sk_q == trg_pkg::TRG_SK_GOT_AA && wdat == trg_pkg::KEY_SECOND
    |=> sk_q == trg_pkg::TRG_SK_OPEN ##1 single_key_unlocked_flag_o)
    else $error("single key not granted");
  tkt_consume_a: assert property (wr_c && sk_ok
      && single_guarded(avs_address_i)
    |=> sk_q == trg_pkg::TRG_SK_LOCKED)
    else $error("ticket not consumed");
  tkt_void_a: assert property (commit && sk_hit && sk_ok
    |=> sk_q == trg_pkg::TRG_SK_LOCKED)
    else $error("ticket not voided");
  tkt_hold_a: assert property (sk_ok && !(commit && sk_hit)
      && !(wr_c && single_guarded(avs_address_i))
    |=> sk_ok) else $error("ticket lost by itself");
  key_flag_a: assert property (sk_ok |=> single_key_unlocked_flag_o)
    else $error("ticket flag not shown");
  sk_read_a: assert property (rd_c && sk_hit
    |-> avs_readdata_o[trg_pkg::STAT_BIT] == sk_ok
        && avs_readdata_o[7:1] == 7'h00)
    else $error("single key status wrong");
  wk_read_a: assert property (rd_c && wk_hit
    |-> avs_readdata_o[trg_pkg::STAT_BIT] == $past(wk_ok)
        && avs_readdata_o[7:1] == 7'h00)
    else $error("window status wrong");
  guard_read_a: assert property (rd_c
      && avs_address_i == trg_pkg::IDX_XRAM_BASE
    |-> avs_readdata_o[7:0] == $past(prot_regs_o.xram_base))
    else $error("guarded read wrong");
  blocked_wr_a: assert property (wr_c && !sk_ok
      && avs_address_i == trg_pkg::IDX_WDOG_CTRL
    |=> $stable(prot_regs_o.wdog_ctrl))
    else $error("locked register changed");
  win_blocked_a: assert property (wr_c && !wk_ok
      && window_guarded(avs_address_i)
    |=> $stable(prot_regs_o.clock_select) && $stable(prot_regs_o.wake_mask)
        && $stable(trim_regs_o))
    else $error("closed window register changed");
  win_wr_a: assert property (wr_c && wk_ok
      && avs_address_i == trg_pkg::IDX_CLOCK_SELECT
    |=> prot_regs_o.clock_select == $past(wdat))
    else $error("window write lost");
  trim_wr_a: assert property (wr_c && wk_ok && slot == 5'h10
    |=> trim_regs_o[0] == $past(wdat))
    else $error("trim write lost");
  win_open_a: assert property (wk_reload ##1 !wk_close [*7]
    |=> wk_ok) else $error("window did not open");
  win_close_a: assert property (wk_close |=> !wk_ok)
    else $error("window did not close");
  seq_reset_a: assert property (wr_c && sk_hit && !sk_ok
      && wdat != trg_pkg::KEY_FIRST && wdat != trg_pkg::KEY_SECOND
    |=> sk_q == trg_pkg::TRG_SK_LOCKED)
    else $error("sequence not reset");
  bus_answer_a: assert property (req && avs_waitrequest_o
    |=> !avs_waitrequest_o) else $error("no answer after one wait");

  grant_c: cover property (wk_reload ##[1:20] wr_c && slot[4]);
  consume_c: cover property (wr_c && sk_ok && single_guarded(avs_address_i));
  extend_c: cover property (wk_reload ##[1:255] wk_reload);
  expire_c: cover property (wk_ok ##1 !wk_ok && !$past(wk_close));
  restart_c: cover property (wr_c && sk_hit
    && sk_q == trg_pkg::TRG_SK_GOT_AA && wdat == trg_pkg::KEY_FIRST);

endmodule

`default_nettype wire

// File: tb/test_timed_register_write_guard.sv
// Purpose: self-checking bench for the timed register write guard
// Assumes: one wait state per access; window shortened to 64 cycles
// Notes:   bench drives the Avalon-MM slave itself, no partner model
`default_nettype none

module test_timed_register_write_guard;
  timeunit 1ns;
  timeprecision 1ps;

  localparam int WIN = 64;
  localparam logic [15:0] SK_IDX [3] = '{trg_pkg::IDX_WDOG_CTRL,
    trg_pkg::IDX_XRAM_BASE, trg_pkg::IDX_ADDR_CONFIG};
  localparam logic [7:0]  SK_RST [3] = '{trg_pkg::RST_WDOG_CTRL,
    trg_pkg::RST_XRAM_BASE, trg_pkg::RST_ADDR_CONFIG};

  logic                              clk_sys_i;
  logic                              rst_i;
  logic [15:0]                       avs_address;
  logic                              avs_read;
  logic                              avs_write;
  logic [31:0]                       avs_writedata;
  logic [3:0]                        avs_byteenable;
  logic [31:0]                       avs_readdata_o;
  logic                              avs_waitrequest_o;
  trg_pkg::trg_prot_s                prot;
  logic [trg_pkg::TRIM_N-1:0][7:0]   trim;
  logic                              single_key_unlocked_flag_o;
  logic                              window_open_flag_o;
  logic [31:0]                       q;
  int                                n_mismatch;
  int                                comparisons;
  int                                cnt;

  trg_guard #(.WINDOW_CYCLES(WIN)) u_trg_guard (
    .clk_sys_i                  (clk_sys_i),
    .rst_i                      (rst_i),
    .avs_address_i              (avs_address),
    .avs_read_i                 (avs_read),
    .avs_write_i                (avs_write),
    .avs_writedata_i            (avs_writedata),
    .avs_byteenable_i           (avs_byteenable),
    .avs_readdata_o             (avs_readdata_o),
    .avs_waitrequest_o          (avs_waitrequest_o),
    .prot_regs_o                (prot),
    .trim_regs_o                (trim),
    .single_key_unlocked_flag_o (single_key_unlocked_flag_o),
    .window_open_flag_o         (window_open_flag_o)
  );

  initial begin
    clk_sys_i = 1'b0;
    forever #20 clk_sys_i = ~clk_sys_i;
  end

  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic check(input string nm, input logic [63:0] seen,
                       input logic [63:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // one access: hold until waitrequest sampled low, then release
  task automatic bus(input logic wr, input logic [15:0] a,
                     input logic [7:0] d);
    int n;
    @(posedge clk_sys_i);
    avs_address   <= a;
    avs_writedata <= {24'h000000, d};
    avs_write     <= wr;
    avs_read      <= ~wr;
    n = 0;
    do begin
      @(posedge clk_sys_i);
      n++;
    end while (avs_waitrequest_o !== 1'b0 && n < 20);
    q = avs_readdata_o;
    avs_write <= 1'b0;
    avs_read  <= 1'b0;
    if (n >= 20) begin
      n_mismatch++;
      end_of_test();
    end
  endtask

  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    bus(1'b1, a, d);
  endtask

  task automatic rd_chk(input string nm, input logic [15:0] a,
                        input logic [7:0] e);
    bus(1'b0, a, 8'h00);
    check(nm, q, {24'h000000, e});
  endtask

  task automatic key_seq(input logic [15:0] a);
    wr(a, trg_pkg::KEY_FIRST);
    wr(a, trg_pkg::KEY_SECOND);
    repeat (2) @(posedge clk_sys_i);
  endtask

  // count cycles the window flag stays high after the accept edge
  task automatic count_open();
    cnt = 0;
    for (int k = 0; k < WIN + 20; k++) begin
      @(posedge clk_sys_i);
      if (window_open_flag_o !== 1'b1) break;
      cnt++;
    end
  endtask

  initial begin
    rst_i          = 1'b1;
    avs_address    = 16'h0000;
    avs_read       = 1'b0;
    avs_write      = 1'b0;
    avs_writedata  = 32'h00000000;
    avs_byteenable = 4'hF;
    n_mismatch     = 0;
    comparisons    = 0;
    repeat (3) @(posedge clk_sys_i);
    rst_i <= 1'b0;
    // reset values, reads while locked, writes without permission
    for (int i = 0; i < 3; i++) begin
      rd_chk("ticket reg reset", SK_IDX[i], SK_RST[i]);
      wr(SK_IDX[i], 8'h5A);
      rd_chk("ticket reg locked", SK_IDX[i], SK_RST[i]);
    end
    rd_chk("clock select", trg_pkg::IDX_CLOCK_SELECT, 8'h0C);
    wr(trg_pkg::IDX_CLOCK_SELECT, 8'h5A);
    rd_chk("clock select", trg_pkg::IDX_CLOCK_SELECT, 8'h0C);
    rd_chk("wake mask", trg_pkg::IDX_WAKE_MASK, 8'hFF);
    rd_chk("window key", trg_pkg::IDX_WINDOW_KEY, 8'h00);
    check("trim reset", trim[0], 8'h00);
    // one ticket, one guarded write
    for (int i = 0; i < 3; i++) begin
      key_seq(trg_pkg::IDX_SINGLE_KEY);
      check("ticket flag", single_key_unlocked_flag_o, 1'b1);
      wr(SK_IDX[i], 8'h11 + 8'(i));
      repeat (2) @(posedge clk_sys_i);
      check("ticket used", single_key_unlocked_flag_o, 1'b0);
      wr(SK_IDX[i], 8'h77);
      rd_chk("ticket write", SK_IDX[i], 8'h11 + 8'(i));
    end
    check("guarded out", prot.wdog_ctrl, 8'h11);
    check("xram out", prot.xram_base, 8'h12);
    check("config out", prot.addr_config, 8'h13);
    // no timeout, voided by a key read
    key_seq(trg_pkg::IDX_SINGLE_KEY);
    repeat (300) @(posedge clk_sys_i);
    check("ticket held", single_key_unlocked_flag_o, 1'b1);
    bus(1'b0, trg_pkg::IDX_SINGLE_KEY, 8'h00);
    check("key status", q[0], 1'b1);
    wr(trg_pkg::IDX_WDOG_CTRL, 8'h99);
    rd_chk("voided", trg_pkg::IDX_WDOG_CTRL, 8'h11);
    // broken sequences
    wr(trg_pkg::IDX_SINGLE_KEY, trg_pkg::KEY_SECOND);
    wr(trg_pkg::IDX_SINGLE_KEY, trg_pkg::KEY_FIRST);
    wr(trg_pkg::IDX_SINGLE_KEY, 8'h12);
    wr(trg_pkg::IDX_SINGLE_KEY, trg_pkg::KEY_SECOND);
    repeat (2) @(posedge clk_sys_i);
    check("broken seq", single_key_unlocked_flag_o, 1'b0);
    // repeated first byte restarts, a key write voids
    wr(trg_pkg::IDX_SINGLE_KEY, trg_pkg::KEY_FIRST);
    key_seq(trg_pkg::IDX_SINGLE_KEY);
    check("restart seq", single_key_unlocked_flag_o, 1'b1);
    wr(trg_pkg::IDX_SINGLE_KEY, 8'h00);
    repeat (2) @(posedge clk_sys_i);
    check("write void", single_key_unlocked_flag_o, 1'b0);
    // window: many writes, then early close
    key_seq(trg_pkg::IDX_WINDOW_KEY);
    bus(1'b0, trg_pkg::IDX_WINDOW_KEY, 8'h00);
    check("window status", q[0], 1'b1);
    wr(trg_pkg::IDX_CLOCK_SELECT, 8'h03);
    wr(trg_pkg::IDX_WAKE_MASK, 8'h3C);
    for (int i = 0; i < trg_pkg::TRIM_N; i++) begin
      wr(trg_pkg::IDX_TRIM[i], 8'h40 + 8'(i));
    end
    avs_byteenable <= 4'hE;
    wr(trg_pkg::IDX_WAKE_MASK, 8'h00);
    avs_byteenable <= 4'hF;
    wr(trg_pkg::IDX_WINDOW_KEY, trg_pkg::KEY_CLOSE);
    repeat (2) @(posedge clk_sys_i);
    check("window closed", window_open_flag_o, 1'b0);
    wr(trg_pkg::IDX_CLOCK_SELECT, 8'hFF);
    rd_chk("clock select", trg_pkg::IDX_CLOCK_SELECT, 8'h03);
    rd_chk("wake mask", trg_pkg::IDX_WAKE_MASK, 8'h3C);
    check("wake out", prot.wake_mask, 8'h3C);
    check("clock out", prot.clock_select, 8'h03);
    for (int i = 0; i < trg_pkg::TRIM_N; i++) begin
      rd_chk("trim", trg_pkg::IDX_TRIM[i], 8'h40 + 8'(i));
      check("trim out", trim[i], 8'h40 + 8'(i));
    end
    rd_chk("window key", trg_pkg::IDX_WINDOW_KEY, 8'h00);
    // window length, expiry and reload
    wr(trg_pkg::IDX_WINDOW_KEY, trg_pkg::KEY_FIRST);
    wr(trg_pkg::IDX_WINDOW_KEY, trg_pkg::KEY_SECOND);
    count_open();
    check("window length", cnt, WIN);
    wr(trg_pkg::IDX_WAKE_MASK, 8'h01);
    rd_chk("expired", trg_pkg::IDX_WAKE_MASK, 8'h3C);
    key_seq(trg_pkg::IDX_WINDOW_KEY);
    repeat (WIN - 12) @(posedge clk_sys_i);
    wr(trg_pkg::IDX_WINDOW_KEY, trg_pkg::KEY_FIRST);
    wr(trg_pkg::IDX_WINDOW_KEY, trg_pkg::KEY_SECOND);
    count_open();
    check("reload length", cnt, WIN);
    end_of_test();
  end
endmodule

`default_nettype wire
